/* verilog/hdoo_cfg.svh */
`ifndef HDOO_CFG_SVH
`define HDOO_CFG_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HDOO_CLK_HZ     250000000
`define HDOO_QTR_MS     250
`define HDOO_HOLD_MS    2000
`define HDOO_TIMEOUT_S  3600
`define HDOO_QTR_PER_S  (1000 / `HDOO_QTR_MS)
`define HDOO_QTR_CYC    ((`HDOO_CLK_HZ / 1000) * `HDOO_QTR_MS)
`define HDOO_HOLD_CYC   ((`HDOO_CLK_HZ / 1000) * `HDOO_HOLD_MS)
`define HDOO_TIMEOUT_Q  (`HDOO_TIMEOUT_S * `HDOO_QTR_PER_S)
`define HDOO_STEP_Q     `HDOO_QTR_PER_S
`define HDOO_STEP_FIRST 4'h1
`define HDOO_STEP_LAST  4'hA
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define HDOO_ADDR_CTRL   8'h00
`define HDOO_ADDR_OADMIN 8'h04
`define HDOO_ADDR_DIAG   8'h08
`define HDOO_ADDR_TEST   8'h0C
`define HDOO_ADDR_OCNT   8'h10
`define HDOO_ADDR_ORDER  8'h40
`define HDOO_ADDR_END    8'h84
`define HDOO_CTRL_CLR    0
`define HDOO_CTRL_CFG    1
`define HDOO_OADMIN_RST  8'h20
`define HDOO_RESP_OKAY   2'h0
`define HDOO_RESP_SLVERR 2'h2
// ------------------------------------------------------------
// Diagnostics
// ------------------------------------------------------------
`define HDOO_N_DIAG    17
`define HDOO_D_EWT     4
`define HDOO_D_OAT     7
`define HDOO_D_DEFROST 11
`define HDOO_D_INVCFG  16
`define HDOO_M_CLOSED  17'h0004D
`define HDOO_M_OPEN    17'h00022
`define HDOO_M_LATCH   17'h19027
`define HDOO_M_TWOBLK  17'h1006F
`define HDOO_PAT_BLINK 8'hF0
`define HDOO_PAT_TWO   8'hA0
`endif

/* verilog/hdoo_pkg.sv */
package hdoo_pkg;
   typedef enum logic [3:0] {
      HDOO_IDLE  = 4'h1,
      HDOO_PRESS = 4'h2,
      HDOO_ARMED = 4'h4,
      HDOO_TEST  = 4'h8
   } hdoo_state_t;
   typedef enum logic [1:0] {
      HDOO_REQ_NONE = 2'h0,
      HDOO_REQ_EN   = 2'h1,
      HDOO_REQ_DIS  = 2'h2,
      HDOO_REQ_RSV  = 2'h3
   } hdoo_econ_t;
endpackage

/* verilog/hdoo_top.sv */
`timescale 1ns/1ps
`include "hdoo_cfg.svh"
// Contract
// - Test mode ends by itself after the last step, or after one hour at most
// - Test steps advance at most once per second
// - Status LED dark while button held
// - Enter test after two-second hold, then release
// - Status LED blinks during test mode
// - Overflow/airflow/space/discharge failure: full shutdown, valves closed
// - Low coil or discharge limit: shutdown, valves open
// - Entering water failure: baseboard heat and cooling valve off
// - Outdoor air failure: damper to minimum position
// - Report-only diagnostics leave outputs alone
// - Defrost lockout: DX/electric heat off
// - Invalid configuration disables all controlled outputs
// - Generic binary output ignores diagnostics
// - Any shutdown or invalid configuration in test: two-blink LED
// - Sensor diagnostics clear when input valid
// - Water sensor failed: no hydronic cooling
// - Outdoor air failed: local economizer decision inhibited
// - Supervisory economizer request overrides local decision
// - Economizer request needs economizer configuration
// - Each diagnostic recorded independently
// - Diagnostics reported in order raised
// - First and last test step clear diagnostics
module hdoo_top
   import hdoo_pkg::*;
#(
   parameter int unsigned P_QTR_CYC  = `HDOO_QTR_CYC,
   parameter int unsigned P_HOLD_CYC = `HDOO_HOLD_CYC,
   parameter int unsigned P_TMO_Q    = `HDOO_TIMEOUT_Q
) (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_B,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   output logic [1:0]       O_BRESP,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   input  wire logic [7:0]  I_ARADDR,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   input  wire logic        I_TEST_BTN,
   input  wire logic [16:0] I_DIAG_RAW,
   input  wire logic        I_FAN_REQ,
   input  wire logic        I_COOL_VALVE_REQ,
   input  wire logic        I_HEAT_VALVE_REQ,
   input  wire logic [7:0]  I_OAD_POS,
   input  wire logic        I_FACE_REQ,
   input  wire logic        I_DX_HEAT_REQ,
   input  wire logic        I_BASE_HEAT_REQ,
   input  wire logic        I_GEN_BO_REQ,
   input  wire logic        I_ECON_LOCAL,
   output logic             O_FAN,
   output logic             O_COOL_VALVE,
   output logic             O_HEAT_VALVE,
   output logic [7:0]       O_OAD_POS,
   output logic             O_FACE,
   output logic             O_DX_HEAT,
   output logic             O_BASE_HEAT,
   output logic             O_GEN_BO,
   output logic             O_ECON,
   output logic             O_STATUS_LED,
   output logic             O_TEST_MODE,
   output logic [3:0]       O_TEST_STEP
);
   localparam int N = `HDOO_N_DIAG;
   function automatic logic hdoo_mapped(input logic [7:0] a);
      hdoo_mapped = (a == `HDOO_ADDR_CTRL) || (a == `HDOO_ADDR_OADMIN) ||
                    (a == `HDOO_ADDR_DIAG) || (a == `HDOO_ADDR_TEST) ||
                    (a == `HDOO_ADDR_OCNT) ||
                    ((a >= `HDOO_ADDR_ORDER) && (a < `HDOO_ADDR_END) &&
                     (a[1:0] == 2'h0));
   endfunction
   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [31:0]      rdata_r;
   logic [1:0]       rresp_r;
   logic             cfg_r;
   hdoo_econ_t       req_r;
   logic [7:0]       oadmin_r;
   logic [31:0]      rdata_nxt;
   logic [16:0]      diag_r;
   logic [4:0]       slot_r [N];
   logic [4:0]       cnt_r;
   hdoo_state_t      st_r;
   logic [3:0]       step_r;
   wire wr_go  = I_AWVALID & I_WVALID & ~bvalid_r;
   wire rd_go  = I_ARVALID & ~rvalid_r;
   wire wr_low = wr_go & I_WSTRB[0];
   wire wr_ctrl = wr_low & (I_AWADDR == `HDOO_ADDR_CTRL);
   wire wr_oad  = wr_low & (I_AWADDR == `HDOO_ADDR_OADMIN);
   wire sw_clr  = wr_ctrl & I_WDATA[`HDOO_CTRL_CLR];
   wire [7:0] ord_off = I_ARADDR - `HDOO_ADDR_ORDER;
   wire [4:0] oidx = ord_off[6:2];
   assign O_AWREADY = wr_go;
   assign O_WREADY  = wr_go;
   assign O_ARREADY = rd_go;
   assign O_BVALID  = bvalid_r;
   assign O_BRESP   = bresp_r;
   assign O_RVALID  = rvalid_r;
   assign O_RDATA   = rdata_r;
   assign O_RRESP   = rresp_r;
   always_comb begin
      rdata_nxt = 32'h0;
      case (I_ARADDR)
         `HDOO_ADDR_CTRL:   rdata_nxt = {28'h0, req_r, cfg_r, 1'b0};
         `HDOO_ADDR_OADMIN: rdata_nxt = {24'h0, oadmin_r};
         `HDOO_ADDR_DIAG:   rdata_nxt = {15'h0, diag_r};
         `HDOO_ADDR_TEST:   rdata_nxt = {23'h0, O_ECON, step_r, st_r};
         `HDOO_ADDR_OCNT:   rdata_nxt = {27'h0, cnt_r};
         default: begin
            if (hdoo_mapped(I_ARADDR) && (oidx < cnt_r)) begin
               // Bit 5 marks an occupied slot
               rdata_nxt = {26'h0, 1'b1, slot_r[oidx]};
            end
         end
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `HDOO_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= `HDOO_RESP_OKAY;
      end else begin
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= hdoo_mapped(I_AWADDR) ? `HDOO_RESP_OKAY
                                              : `HDOO_RESP_SLVERR;
         end else if (I_BREADY) begin
            bvalid_r <= 1'b0;
         end
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdata_nxt;
            rresp_r  <= hdoo_mapped(I_ARADDR) ? `HDOO_RESP_OKAY
                                              : `HDOO_RESP_SLVERR;
         end else if (I_RREADY) begin
            rvalid_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         cfg_r    <= 1'b0;
         req_r    <= HDOO_REQ_NONE;
         oadmin_r <= `HDOO_OADMIN_RST;
      end else begin
         if (wr_ctrl) begin
            cfg_r <= I_WDATA[`HDOO_CTRL_CFG];
            req_r <= hdoo_econ_t'(I_WDATA[3:2]);
         end
         if (wr_oad) begin
            oadmin_r <= I_WDATA[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Test mode supervision
   // ------------------------------------------------------------
   logic [31:0]      qcnt_r;
   logic [31:0]      hold_r;
   logic [2:0]       sq_r;
   logic [15:0]      tmo_r;
   logic [2:0]       ph_r;
   hdoo_state_t      st_nxt;
   wire qtick     = (qcnt_r == 32'(P_QTR_CYC - 1));
   wire in_test   = (st_r == HDOO_TEST);
   wire held      = (hold_r == 32'(P_HOLD_CYC - 1));
   wire step_adv  = qtick & (sq_r == 3'(`HDOO_STEP_Q - 1));
   wire tmo_hit   = qtick & (tmo_r == 16'(P_TMO_Q - 1));
   wire step_done = step_adv & (step_r == `HDOO_STEP_LAST);
   wire enter     = (st_r == HDOO_ARMED) & ~I_TEST_BTN;
   wire leave     = in_test & (tmo_hit | step_done);
   wire last_in   = in_test & step_adv &
                    (step_r == `HDOO_STEP_LAST - 4'h1);
   wire step_clr  = enter | last_in;
   always_comb begin
      unique case (st_r)
         HDOO_IDLE:  st_nxt = I_TEST_BTN ? HDOO_PRESS : HDOO_IDLE;
         HDOO_PRESS: st_nxt = !I_TEST_BTN ? HDOO_IDLE :
                              held ? HDOO_ARMED : HDOO_PRESS;
         HDOO_ARMED: st_nxt = I_TEST_BTN ? HDOO_ARMED : HDOO_TEST;
         HDOO_TEST:  st_nxt = leave ? HDOO_IDLE : HDOO_TEST;
         default:    st_nxt = HDOO_IDLE;
      endcase
   end

   // Step pacing runs off the quarter-second tick; outputs carry no
   // minimum on/off timers, so the one-second step is the only hold
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         st_r   <= HDOO_IDLE;
         qcnt_r <= 32'h0;
         hold_r <= 32'h0;
         sq_r   <= 3'h0;
         tmo_r  <= 16'h0;
         ph_r   <= 3'h0;
         step_r <= 4'h0;
      end else begin
         st_r   <= st_nxt;
         qcnt_r <= qtick ? 32'h0 : qcnt_r + 32'h1;
         hold_r <= (st_r == HDOO_PRESS) ? hold_r + 32'h1 : 32'h0;
         if (enter) begin
            step_r <= `HDOO_STEP_FIRST;
            sq_r   <= 3'h0;
            tmo_r  <= 16'h0;
            ph_r   <= 3'h0;
         end else if (!in_test || leave) begin
            step_r <= 4'h0;
         end else if (qtick) begin
            sq_r   <= step_adv ? 3'h0 : sq_r + 3'h1;
            step_r <= step_r + {3'h0, step_adv};
            tmo_r  <= tmo_r + 16'h1;
            ph_r   <= ph_r + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Diagnostic record and order of arrival
   // ------------------------------------------------------------
   wire        clr_all  = sw_clr | step_clr;
   wire [16:0] nonlatch = I_DIAG_RAW & ~`HDOO_M_LATCH;
   wire [16:0] latched  = `HDOO_M_LATCH &
                          (I_DIAG_RAW | (diag_r & {N{~clr_all}}));
   // A raw event in the clearing cycle is kept: set wins
   wire [16:0] diag_nxt = nonlatch | latched;
   logic [4:0]  lst_nxt [N];
   logic [4:0]  cnt_nxt;
   // Survivors keep their order; at most one newcomer per cycle is
   // appended, lowest index first, so simultaneous raises still queue
   always_comb begin
      logic [16:0] kept;
      logic [16:0] pend;
      logic [4:0]  k;
      logic [4:0]  newi;
      kept = 17'h0;
      pend = 17'h0;
      k    = 5'h0;
      newi = 5'h0;
      for (int i = 0; i < N; i++) begin
         lst_nxt[i] = 5'h0;
      end
      for (int i = 0; i < N; i++) begin
         if ((5'(i) < cnt_r) && diag_r[slot_r[i]]) begin
            lst_nxt[k]        = slot_r[i];
            kept[slot_r[i]]   = 1'b1;
            k                 = k + 5'h1;
         end
      end
      pend = diag_r & ~kept;
      for (int j = N - 1; j >= 0; j--) begin
         if (pend[j]) begin
            newi = 5'(j);
         end
      end
      if (|pend) begin
         lst_nxt[k] = newi;
         k          = k + 5'h1;
      end
      cnt_nxt = k;
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         diag_r <= 17'h0;
         cnt_r  <= 5'h0;
         for (int i = 0; i < N; i++) begin
            slot_r[i] <= 5'h0;
         end
      end else begin
         diag_r <= diag_nxt;
         cnt_r  <= cnt_nxt;
         for (int i = 0; i < N; i++) begin
            slot_r[i] <= lst_nxt[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Output forcing
   // ------------------------------------------------------------
   // Report-only bits sit in neither shutdown mask and so force nothing
   wire shut_cl = |(diag_r & `HDOO_M_CLOSED);
   wire shut_op = |(diag_r & `HDOO_M_OPEN);
   wire inv     = diag_r[`HDOO_D_INVCFG];
   wire ewt     = diag_r[`HDOO_D_EWT];
   wire oat     = diag_r[`HDOO_D_OAT];
   wire defrost = diag_r[`HDOO_D_DEFROST];
   wire shut    = shut_cl | shut_op | inv;
   // Invalid setup beats freeze protection, which beats closing
   wire vforce  = inv | shut_op | shut_cl;
   wire vforced = ~inv & shut_op;
   wire cv_nxt  = vforce ? vforced
                         : (I_COOL_VALVE_REQ & ~ewt);
   wire hv_nxt  = vforce ? vforced : I_HEAT_VALVE_REQ;
   wire [7:0] oad_nxt = shut ? 8'h00 :
                        oat ? oadmin_r : I_OAD_POS;
   wire econ_dec = (req_r == HDOO_REQ_EN)  ? 1'b1 :
                   (req_r == HDOO_REQ_DIS) ? 1'b0 :
                   (~oat & I_ECON_LOCAL);
   wire econ_nxt = cfg_r & econ_dec & ~shut;
   wire twoblk   = |(diag_r & `HDOO_M_TWOBLK);
   wire [7:0] pat = twoblk ? `HDOO_PAT_TWO
                           : `HDOO_PAT_BLINK;
   wire led_nxt  = I_TEST_BTN ? 1'b0 :
                   in_test ? pat[~ph_r] : 1'b1;

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         O_FAN        <= 1'b0;
         O_COOL_VALVE <= 1'b0;
         O_HEAT_VALVE <= 1'b0;
         O_OAD_POS    <= 8'h00;
         O_FACE       <= 1'b0;
         O_DX_HEAT    <= 1'b0;
         O_BASE_HEAT  <= 1'b0;
         O_GEN_BO     <= 1'b0;
         O_ECON       <= 1'b0;
         O_STATUS_LED <= 1'b0;
         O_TEST_MODE  <= 1'b0;
         O_TEST_STEP  <= 4'h0;
      end else begin
         O_FAN        <= I_FAN_REQ & ~shut;
         O_COOL_VALVE <= cv_nxt;
         O_HEAT_VALVE <= hv_nxt;
         O_OAD_POS    <= oad_nxt;
         O_FACE       <= I_FACE_REQ & ~shut;
         O_DX_HEAT    <= I_DX_HEAT_REQ & ~shut & ~defrost;
         O_BASE_HEAT  <= I_BASE_HEAT_REQ & ~shut & ~ewt;
         O_GEN_BO     <= I_GEN_BO_REQ;
         O_ECON       <= econ_nxt;
         O_STATUS_LED <= led_nxt;
         O_TEST_MODE  <= (st_nxt == HDOO_TEST);
         O_TEST_STEP  <= step_r;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_B);
   led_dark_a: assert property (I_TEST_BTN |=> !O_STATUS_LED)
      else $error("LED lit while button held");
   fan_shut_a: assert property (shut |=> !O_FAN && !O_DX_HEAT
                                && !O_BASE_HEAT && O_OAD_POS == 8'h00)
      else $error("Shutdown did not force outputs");
   valve_open_a: assert property (shut_op && !inv |=>
                                  O_COOL_VALVE && O_HEAT_VALVE)
      else $error("Valves not opened");
   inv_cfg_a: assert property (inv |=> !O_COOL_VALVE && !O_HEAT_VALVE
                               && !O_FACE && !O_FAN)
      else $error("Invalid configuration left outputs on");
   ewt_base_a: assert property (ewt |=> !O_BASE_HEAT &&
                                (!O_COOL_VALVE || $past(shut_op && !inv)))
      else $error("Water sensor failure not honoured");
   oat_min_a: assert property (oat && !shut |=>
                               O_OAD_POS == $past(oadmin_r))
      else $error("Damper not at minimum");
   gen_bo_a: assert property (1'b1 |=>
                              O_GEN_BO == $past(I_GEN_BO_REQ))
      else $error("Generic output disturbed");
   defrost_a: assert property (defrost |=> !O_DX_HEAT)
      else $error("DX heat on during defrost");
   test_enter_a: assert property ($rose(O_TEST_MODE) |->
                                  $past(st_r) == HDOO_ARMED)
      else $error("Test entered without hold");
   step_pace_a: assert property (in_test && $changed(step_r) &&
                                 $past(in_test) |-> $past(step_adv))
      else $error("Step advanced early");
   timeout_a: assert property (in_test && tmo_hit |=> st_r == HDOO_IDLE)
      else $error("Test did not time out");
   nonlatch_a: assert property (1'b1 |=> (diag_r & ~`HDOO_M_LATCH) ==
                               ($past(I_DIAG_RAW) & ~`HDOO_M_LATCH))
      else $error("Sensor diagnostic latched");
   econ_cfg_a: assert property (!cfg_r |=> !O_ECON)
      else $error("Economizer on while unconfigured");
endmodule // hdoo_top

/* tb/hdoo_plant.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operator at the unit's test button
// ------------------------------------------------------------
module hdoo_plant (
   input  wire logic i_clk,
   output logic      o_btn
);
   initial o_btn = 1'b0;
   // Holds of n cycles model the operator; the bench asks for one short hold and one full hold
   task automatic press(input int n);
      @(posedge i_clk);
      o_btn <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_btn <= 1'b0;
   endtask
endmodule // hdoo_plant

/* tb/tb_hvac_diagnostic_output_override.sv */
`timescale 1ns/1ps
`include "hdoo_cfg.svh"
module tb_hvac_diagnostic_output_override;
   import hdoo_pkg::*;
   // Shortened counts keep the run under a thousand cycles
   localparam int QC = 8;
   localparam int HC = 20;
   localparam int TQ = 20;
   logic              clk, rst_b, awv, wv, bre, arv, rre;
   logic [7:0]        awa, ara;
   logic [31:0]       wd, rd;
   logic [16:0]       raw;
   logic [15:0]       rq;
   logic [1:0]        rsp;
   wire  logic        awr, wr, bv, arr, rv, led, tm, btn;
   wire  logic [1:0]  br, rr;
   wire  logic [31:0] rdat;
   wire  logic [3:0]  step;
   wire  logic [15:0] ov;
   int                mismatches = 0;
   int                n_checks = 0;
   int                n, sc;
   time               t0;
   logic [3:0]        ps;
   int                ord [3] = '{7, 4, 2};
   logic [7:0]        etab [5] = '{8'h73, 8'hA4, 8'h40, 8'h26, 8'hE5};

   hdoo_top #(.P_QTR_CYC(QC), .P_HOLD_CYC(HC), .P_TMO_Q(TQ)) i_dut (
      .I_CLOCK(clk), .I_RST_B(rst_b),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
      .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hF),
      .O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br),
      .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
      .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rr),
      .I_TEST_BTN(btn), .I_DIAG_RAW(raw),
      .I_FAN_REQ(rq[15]), .I_COOL_VALVE_REQ(rq[14]),
      .I_HEAT_VALVE_REQ(rq[13]), .I_OAD_POS(rq[12:5]), .I_FACE_REQ(rq[4]),
      .I_DX_HEAT_REQ(rq[3]), .I_BASE_HEAT_REQ(rq[2]), .I_GEN_BO_REQ(rq[1]),
      .I_ECON_LOCAL(rq[0]), .O_FAN(ov[15]), .O_COOL_VALVE(ov[14]),
      .O_HEAT_VALVE(ov[13]), .O_OAD_POS(ov[12:5]), .O_FACE(ov[4]),
      .O_DX_HEAT(ov[3]), .O_BASE_HEAT(ov[2]), .O_GEN_BO(ov[1]),
      .O_ECON(ov[0]), .O_STATUS_LED(led), .O_TEST_MODE(tm),
      .O_TEST_STEP(step)
   );
   hdoo_plant i_plant (.i_clk(clk), .o_btn(btn));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      do @(posedge clk); while (awr !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      bre <= 1'b1;
      do @(posedge clk); while (bv !== 1'b1);
      rsp = br;
      bre <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      rre <= 1'b1;
      do @(posedge clk); while (rv !== 1'b1);
      rd = rdat;
      rsp = rr;
      rre <= 1'b0;
   endtask

   task automatic wait_tm(input logic v);
      int k;
      k = 0;
      while (tm !== v && k < 400) begin
         @(posedge clk);
         k++;
      end
      check(tm, v);
   endtask

   // Outputs expected for a set of active diagnostics, mildest first
   function automatic logic [15:0] exp_out(input logic [16:0] d,
                                           input logic [15:0] r);
      logic [15:0] e;
      e = r;
      if (d[`HDOO_D_DEFROST]) e[3] = 1'b0;
      if (d[`HDOO_D_OAT]) begin
         e[12:5] = `HDOO_OADMIN_RST;
         e[0] = 1'b0;
      end
      if (d[`HDOO_D_EWT]) begin
         e[14] = 1'b0;
         e[2] = 1'b0;
      end
      if ((d & `HDOO_M_CLOSED) != 17'h0) e = {14'h0, r[1], 1'b0};
      if ((d & `HDOO_M_OPEN) != 17'h0) e = {3'b011, 11'h0, r[1], 1'b0};
      if (d[`HDOO_D_INVCFG]) e = {14'h0, r[1], 1'b0};
      return e;
   endfunction

   // Step spacing monitor
   always @(posedge clk) begin
      sc <= sc + 1;
      ps <= step;
      if (step !== ps) begin
         sc <= 1;
         if (step > 4'h2) check(sc, 32);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {awv, wv, bre, arv, rre} = '0;
      {awa, ara, wd, raw} = '0;
      rq = 16'hEABF;
      sc = 0;
      ps = 4'h0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      axr(`HDOO_ADDR_OADMIN);
      check(rd, 32'h20);
      axr(`HDOO_ADDR_END);
      check(rsp, `HDOO_RESP_SLVERR);
      check(rd, 32'h0);
      axw(`HDOO_ADDR_DIAG, 32'h1FFFF);
      check(rsp, `HDOO_RESP_OKAY);
      axw(`HDOO_ADDR_CTRL, 32'h3);
      axr(`HDOO_ADDR_DIAG);
      check(rd, 32'h0);
      for (int i = 0; i < 17; i++) begin
         raw <= 17'h1 << i;
         repeat (4) @(posedge clk);
         check(ov, exp_out(17'h1 << i, rq));
         check(ov[1], 1'b1);
         axr(`HDOO_ADDR_DIAG);
         check(rd, 32'h1 << i);
         raw <= '0;
         repeat (4) @(posedge clk);
         check(ov, exp_out((17'h1 << i) & `HDOO_M_LATCH, rq));
         axw(`HDOO_ADDR_CTRL, 32'h3);
         repeat (4) @(posedge clk);
         check(ov, rq);
      end
      raw <= 17'h10002;
      repeat (4) @(posedge clk);
      check(ov, exp_out(17'h10002, rq));
      raw <= 17'h00080;
      axw(`HDOO_ADDR_CTRL, 32'h3);
      raw <= 17'h00090;
      @(posedge clk);
      raw <= 17'h00094;
      repeat (4) @(posedge clk);
      axr(`HDOO_ADDR_OCNT);
      check(rd, 32'h3);
      for (int k = 0; k < 3; k++) begin
         axr(`HDOO_ADDR_ORDER + 8'(4 * k));
         check(rd, 32'h20 | ord[k]);
      end
      raw <= '0;
      for (int e = 0; e < 5; e++) begin
         axw(`HDOO_ADDR_CTRL, {28'h0, etab[e][7:4]});
         rq[0] <= etab[e][2];
         raw <= {9'h0, etab[e][1], 7'h0};
         repeat (4) @(posedge clk);
         check(ov[0], etab[e][0]);
      end
      rq[0] <= 1'b1;
      raw <= 17'h00001;
      axw(`HDOO_ADDR_CTRL, 32'h3);
      raw <= '0;
      axr(`HDOO_ADDR_DIAG);
      check(rd, 32'h1);
      check(led, 1'b1);
      fork
         i_plant.press(HC / 2);
         begin
            repeat (5) @(posedge clk);
            check(led, 1'b0);
         end
      join
      repeat (4) @(posedge clk);
      check(tm, 1'b0);
      i_plant.press(HC + 4);
      wait_tm(1'b1);
      t0 = $time;
      axr(`HDOO_ADDR_DIAG);
      check(rd, 32'h0);
      n = 0;
      repeat (64) begin
         @(posedge clk);
         n += int'(led);
      end
      check(n, 32);
      raw <= 17'h10000;
      repeat (8) @(posedge clk);
      raw <= '0;
      n = 0;
      repeat (64) begin
         @(posedge clk);
         n += int'(led);
      end
      check(n, 16);
      wait_tm(1'b0);
      n = int'(($time - t0) / 4);
      check(n >= 148 && n <= 164, 1'b1);
      repeat (2) @(posedge clk);
      check(step, 4'h0);
      complete_run();
   end
endmodule // tb_hvac_diagnostic_output_override
